// *** rtl/tx_guard_params.svh ***
// constants of the transmit guard timer and framer
`ifndef TX_GUARD_PARAMS_SVH
`define TX_GUARD_PARAMS_SVH
`define OFS_PULSE 8'h16
`define OFS_GUARD 8'h17
`define OFS_FRAME 8'h18
`define OFS_CTRL 8'h1a
`define OFS_ISTAT 8'h1b
`define OFS_IMASK 8'h1c
`define MASK_PULSE 32'h0000_ffff
`define MASK_GUARD 32'h0fff_ffff
`define MASK_FRAME 32'h0000_3fff
`define MASK_CTRL 32'h01ff_0006
`define RST_REG 32'h0000_0000
`define F_MLEN 15:8
`define F_FPL 7:0
`define F_WAIT 27:8
`define F_RELOAD 7:0
`define F_FLIP 13
`define F_ODD 12
`define F_PAREN 11
`define F_PAY 10
`define F_STOP 9:8
`define F_START 7:6
`define F_GO 0
`define F_CARD 1
`define F_MILLER 2
`define F_BUSY 3
`define F_NBYTES 24:16
`define I_DONE 0
`define I_EMPTY 1
`define ETU_DEFAULT 128
`endif

// *** rtl/tx_guard_pkg.sv ***
// types shared by the transmit guard timer and framer
package tx_guard_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
    typedef struct packed {
        logic valid;
        logic [19:0] wait_val;
        logic [7:0] reload;
    } detect_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } pay_in_t;
    typedef enum logic [1:0] {K_SYM, K_DATA, K_PAR} elem_kind_t;
    typedef struct packed {
        elem_kind_t kind;
        logic [1:0] val;
    } tx_elem_t;
    typedef enum {S_IDLE, S_GUARD, S_HDR, S_START, S_BODY, S_DATA, S_PAR,
        S_TAIL, S_STOP, S_END} seq_state_t;
endpackage

// *** rtl/tx_guard_framer.sv ***
// transmit guard timer, frame sequencer and register file
`timescale 1ns/1ps
`include "tx_guard_params.svh"
module tx_guard_framer #(
    parameter int ETU_TICKS = `ETU_DEFAULT
) (
    // clock and reset
    input logic clk,
    input logic resetn,
    // register port
    input tx_guard_pkg::bus_req_t bus,
    output logic [31:0] rdata,
    output logic irq,
    // carrier tick enable and mode detector
    input logic carrier_tick,
    input tx_guard_pkg::detect_t det,
    // payload source
    input tx_guard_pkg::pay_in_t pay,
    output logic pay_take,
    // transmit stream
    output tx_guard_pkg::tx_elem_t tx_elem,
    output logic tx_elem_valid,
    output logic mod_pulse,
    output logic busy
);
    import tx_guard_pkg::*;

    localparam int ETU_W = $clog2(ETU_TICKS + 1);
    localparam logic [ETU_W-1:0] ETU_LAST = ETU_W'(ETU_TICKS - 1);

    logic [31:0] pulse_reg;
    logic [31:0] guard_reg;
    logic [31:0] frame_reg;
    logic [31:0] ctrl_reg;
    logic [1:0] istat_reg;
    logic [1:0] imask_reg;
    logic [1:0] istat_set;
    seq_state_t state;
    logic [7:0] presc_cnt;
    logic [19:0] wait_cnt;
    logic [ETU_W-1:0] etu_cnt;
    logic [2:0] bit_idx;
    logic [7:0] cur_byte;
    logic [8:0] bytes_left;
    logic [7:0] pulse_cnt;
    logic go;
    logic elem_end;

    function automatic logic wr_hit(input bus_req_t b, input logic [7:0] a);
        wr_hit = b.wr && (b.addr == a);
    endfunction

    function automatic logic par_bit(input logic [7:0] b, input logic odd,
        input logic flip);
        par_bit = ^b ^ odd ^ flip;
    endfunction

    function automatic tx_elem_t mk_elem(input elem_kind_t k,
        input logic [1:0] v);
        mk_elem.kind = k;
        mk_elem.val = v;
    endfunction

    assign go = wr_hit(bus, `OFS_CTRL) && bus.wdata[`F_GO];
    assign elem_end = carrier_tick && (etu_cnt == '0);

    // register writes
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pulse_reg <= `RST_REG;
        else if (wr_hit(bus, `OFS_PULSE))
            pulse_reg <= bus.wdata & `MASK_PULSE;
    end

    // the mode detector has priority over a software write
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            guard_reg <= `RST_REG;
        else if (det.valid)
            guard_reg <= {4'h0, det.wait_val, det.reload};
        else if (wr_hit(bus, `OFS_GUARD))
            guard_reg <= bus.wdata & `MASK_GUARD;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            frame_reg <= `RST_REG;
        else if (wr_hit(bus, `OFS_FRAME))
            frame_reg <= bus.wdata & `MASK_FRAME;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ctrl_reg <= `RST_REG;
        else if (wr_hit(bus, `OFS_CTRL))
            ctrl_reg <= bus.wdata & `MASK_CTRL;
    end

    // interrupt status: write one to clear, a new event wins
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            istat_reg <= 2'h0;
        else if (wr_hit(bus, `OFS_ISTAT))
            istat_reg <= (istat_reg & ~bus.wdata[1:0]) | istat_set;
        else
            istat_reg <= istat_reg | istat_set;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            imask_reg <= 2'h0;
        else if (wr_hit(bus, `OFS_IMASK))
            imask_reg <= bus.wdata[1:0];
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(istat_reg & imask_reg);
    end

    // read data, unmapped addresses read zero
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata <= 32'h0;
        else if (bus.rd)
        begin
            case (bus.addr)
                `OFS_PULSE: rdata <= pulse_reg;
                `OFS_GUARD: rdata <= guard_reg;
                `OFS_FRAME: rdata <= frame_reg;
                `OFS_CTRL: rdata <= ctrl_reg | {28'h0, busy, 3'h0};
                `OFS_ISTAT: rdata <= {30'h0, istat_reg};
                `OFS_IMASK: rdata <= {30'h0, imask_reg};
                default: rdata <= 32'h0;
            endcase
        end
        else
            rdata <= 32'h0;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            busy <= 1'b0;
        else
            busy <= (state != S_IDLE);
    end

    // frame sequencer with guard timer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= S_IDLE;
            presc_cnt <= 8'h0;
            wait_cnt <= 20'h0;
            etu_cnt <= '0;
            bit_idx <= 3'h0;
            cur_byte <= 8'h0;
            bytes_left <= 9'h0;
            tx_elem <= mk_elem(K_SYM, 2'h0);
            tx_elem_valid <= 1'b0;
            pay_take <= 1'b0;
            istat_set <= 2'h0;
        end
        else
        begin
            tx_elem_valid <= 1'b0;
            pay_take <= 1'b0;
            istat_set <= 2'h0;
            if (carrier_tick && etu_cnt != '0)
                etu_cnt <= etu_cnt - 1'b1;
            case (state)
                S_IDLE:
                begin
                    if (go)
                    begin
                        bytes_left <= bus.wdata[`F_NBYTES];
                        if (frame_reg[`F_PAY] && bus.wdata[`F_NBYTES] == '0)
                            istat_set[`I_EMPTY] <= 1'b1;
                        else if (guard_reg[`F_WAIT] == '0)
                            state <= S_HDR;
                        else
                        begin
                            state <= S_GUARD;
                            wait_cnt <= guard_reg[`F_WAIT];
                            if (bus.wdata[`F_CARD])
                                presc_cnt <= pulse_reg[`F_FPL];
                            else
                                presc_cnt <= guard_reg[`F_RELOAD];
                        end
                    end
                end
                S_GUARD:
                begin
                    if (wait_cnt == '0)
                        state <= S_HDR;
                    else if (carrier_tick)
                    begin
                        if (presc_cnt == 8'h0)
                        begin
                            presc_cnt <= guard_reg[`F_RELOAD];
                            wait_cnt <= wait_cnt - 1'b1;
                        end
                        else
                            presc_cnt <= presc_cnt - 1'b1;
                    end
                end
                S_HDR:
                begin
                    if (frame_reg[`F_START] != 2'h0)
                    begin
                        tx_elem <= mk_elem(K_SYM,
                            frame_reg[`F_START] - 2'h1);
                        tx_elem_valid <= 1'b1;
                        etu_cnt <= ETU_LAST;
                        state <= S_START;
                    end
                    else
                        state <= S_BODY;
                end
                S_START:
                begin
                    if (elem_end)
                        state <= S_BODY;
                end
                S_BODY:
                begin
                    if (!frame_reg[`F_PAY] || bytes_left == '0)
                        state <= S_TAIL;
                    else if (pay.valid)
                    begin
                        cur_byte <= pay.data;
                        pay_take <= 1'b1;
                        bit_idx <= 3'h0;
                        tx_elem <= mk_elem(K_DATA, {1'b0, pay.data[0]});
                        tx_elem_valid <= 1'b1;
                        etu_cnt <= ETU_LAST;
                        state <= S_DATA;
                    end
                end
                S_DATA:
                begin
                    if (elem_end)
                    begin
                        if (bit_idx != 3'h7)
                        begin
                            bit_idx <= bit_idx + 3'h1;
                            tx_elem <= mk_elem(K_DATA,
                                {1'b0, cur_byte[bit_idx + 3'h1]});
                            tx_elem_valid <= 1'b1;
                            etu_cnt <= ETU_LAST;
                        end
                        else if (frame_reg[`F_PAREN])
                        begin
                            tx_elem <= mk_elem(K_PAR, {1'b0,
                                par_bit(cur_byte, frame_reg[`F_ODD],
                                frame_reg[`F_FLIP] && bytes_left == 9'h1)});
                            tx_elem_valid <= 1'b1;
                            etu_cnt <= ETU_LAST;
                            state <= S_PAR;
                        end
                        else
                        begin
                            bytes_left <= bytes_left - 9'h1;
                            state <= S_BODY;
                        end
                    end
                end
                S_PAR:
                begin
                    if (elem_end)
                    begin
                        bytes_left <= bytes_left - 9'h1;
                        state <= S_BODY;
                    end
                end
                S_TAIL:
                begin
                    if (frame_reg[`F_STOP] != 2'h0)
                    begin
                        tx_elem <= mk_elem(K_SYM, frame_reg[`F_STOP]);
                        tx_elem_valid <= 1'b1;
                        etu_cnt <= ETU_LAST;
                        state <= S_STOP;
                    end
                    else
                        state <= S_END;
                end
                S_STOP:
                begin
                    if (elem_end)
                        state <= S_END;
                end
                S_END:
                begin
                    istat_set[`I_DONE] <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // miller pulse lasts the programmed length plus one carrier ticks
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mod_pulse <= 1'b0;
            pulse_cnt <= 8'h0;
        end
        else if (tx_elem_valid && tx_elem.kind != K_SYM && ctrl_reg[`F_MILLER])
        begin
            mod_pulse <= 1'b1;
            pulse_cnt <= pulse_reg[`F_MLEN];
        end
        else if (mod_pulse && carrier_tick)
        begin
            if (pulse_cnt == 8'h0)
                mod_pulse <= 1'b0;
            else
                pulse_cnt <= pulse_cnt - 8'h1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_wrap;
        state == S_GUARD && carrier_tick && presc_cnt == 8'h0 &&
            wait_cnt != '0 |=> presc_cnt == $past(guard_reg[`F_RELOAD]) &&
            wait_cnt == $past(wait_cnt) - 20'h1;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("prescaler wrap did not reload and decrement");
    property p_presc_step;
        state == S_GUARD && carrier_tick && presc_cnt != 8'h0 &&
            wait_cnt != '0 |=> presc_cnt == $past(presc_cnt) - 8'h1 &&
            wait_cnt == $past(wait_cnt);
    endproperty
    a_presc_step: assert property (p_presc_step)
        else $error("prescaler did not step by one");
    property p_no_guard;
        state == S_IDLE && go && guard_reg[`F_WAIT] == '0
            |=> state != S_GUARD;
    endproperty
    a_no_guard: assert property (p_no_guard)
        else $error("guard ran with zero guard count");
    property p_first_load;
        state == S_IDLE && go && bus.wdata[`F_CARD] && !frame_reg[`F_PAY] &&
            guard_reg[`F_WAIT] != '0 |=> state == S_GUARD &&
            presc_cnt == $past(pulse_reg[`F_FPL]);
    endproperty
    a_first_load: assert property (p_first_load)
        else $error("first prescaler load not taken from first load");
    // the header state after the guard sends its first element two cycles after the last guard cycle
    property p_hold;
        state == S_GUARD |-> !tx_elem_valid ##1 !tx_elem_valid;
    endproperty
    a_hold: assert property (p_hold)
        else $error("element sent during guard time");
    property p_empty;
        state == S_IDLE && go && frame_reg[`F_PAY] &&
            bus.wdata[`F_NBYTES] == '0
            |=> state == S_IDLE ##1 istat_reg[`I_EMPTY];
    endproperty
    a_empty: assert property (p_empty)
        else $error("empty payload not flagged");
    property p_pulse_len;
        $rose(mod_pulse) |-> pulse_cnt == $past(pulse_reg[`F_MLEN]);
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("miller pulse length wrong");
    property p_parity;
        tx_elem_valid && tx_elem.kind == K_PAR |-> tx_elem.val[0] ==
            (^cur_byte ^ frame_reg[`F_ODD] ^
            (frame_reg[`F_FLIP] && bytes_left == 9'h1));
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity bit wrong");
    property p_stop_sym;
        $rose(state == S_STOP) |-> tx_elem_valid &&
            tx_elem.val == frame_reg[`F_STOP] && frame_reg[`F_STOP] != 2'h0;
    endproperty
    a_stop_sym: assert property (p_stop_sym)
        else $error("stop symbol wrong");
    property p_detect;
        det.valid |=> guard_reg[`F_WAIT] == $past(det.wait_val) &&
            guard_reg[`F_RELOAD] == $past(det.reload);
    endproperty
    a_detect: assert property (p_detect)
        else $error("detector write lost");
endmodule

// *** bench/rf_peer_model.sv ***
// far-side peer: payload source and transmit element recorder
`timescale 1ns/1ps
module rf_peer_model (
    // clock
    input wire logic clk,
    // payload handshake
    input wire logic pay_take,
    output tx_guard_pkg::pay_in_t pay,
    // transmit stream
    input wire tx_guard_pkg::tx_elem_t tx_elem,
    input wire logic tx_elem_valid
);
    import tx_guard_pkg::*;
    logic [7:0] src_q[$];
    tx_elem_t seen_q[$];
    logic stall = 1'b0;
    logic [7:0] last_b = 8'h00;
    initial pay = '0;
    always @(posedge clk)
    begin
        if (pay_take && src_q.size() > 0)
            last_b = src_q.pop_front();
        if (tx_elem_valid)
            seen_q.push_back(tx_elem);
        // an idle data line shows the inverse of the last byte
        pay.valid <= !stall && src_q.size() > 0;
        pay.data <= (!stall && src_q.size() > 0) ? src_q[0] : ~last_b;
    end
endmodule

// *** bench/tb_nfc_tx_guard_and_framing.sv ***
// self-checking testbench of the transmit guard timer and framer
`timescale 1ns/1ps
`include "tx_guard_params.svh"
module tb_nfc_tx_guard_and_framing;
    import tx_guard_pkg::*;
    localparam int ETU = 4;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    bus_req_t bus = '0;
    logic [31:0] rdata;
    logic irq;
    logic carrier_tick = 1'b0;
    detect_t det = '0;
    pay_in_t pay;
    logic pay_take;
    tx_elem_t tx_elem;
    logic tx_elem_valid;
    logic mod_pulse;
    logic busy;
    int miscompares = 0;
    int checks_done = 0;
    logic go_mark = 1'b0;
    logic got_first = 1'b0;
    int ticks = 0;
    int first_ticks = 0;
    int run = 0;
    int last_run = 0;
    tx_elem_t exp_q[$];
    tx_guard_framer #(.ETU_TICKS(ETU)) dut (
        .clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata), .irq(irq),
        .carrier_tick(carrier_tick), .det(det), .pay(pay),
        .pay_take(pay_take), .tx_elem(tx_elem),
        .tx_elem_valid(tx_elem_valid), .mod_pulse(mod_pulse), .busy(busy)
    );
    rf_peer_model peer (
        .clk(clk), .pay_take(pay_take), .pay(pay), .tx_elem(tx_elem),
        .tx_elem_valid(tx_elem_valid)
    );
    always #50 clk = ~clk;
    // one carrier tick every second clock
    always @(posedge clk)
        carrier_tick <= ~carrier_tick;
    // ticks from go to first element, and miller pulse length in ticks
    always @(posedge clk)
    begin
        if (go_mark)
        begin
            ticks <= 0;
            got_first <= 1'b0;
        end
        else if (!got_first && tx_elem_valid)
        begin
            first_ticks <= ticks;
            got_first <= 1'b1;
        end
        else if (!got_first && carrier_tick)
            ticks <= ticks + 1;
        if (mod_pulse)
            run <= run + int'(carrier_tick);
        else if (run != 0)
        begin
            last_run <= run;
            run <= 0;
        end
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        go_mark <= (a == `OFS_CTRL) && d[0];
        @(posedge clk);
        bus.wr <= 1'b0;
        go_mark <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 check(rdata, e);
    endtask
    task automatic go(input logic [8:0] n, input logic [1:0] mode);
        wr(`OFS_CTRL, {7'h0, n, 13'h0, mode, 1'b1});
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        while (busy !== 1'b0)
        begin
            @(posedge clk);
            n++;
            if (n > 20000)
            begin
                miscompares++;
                summarize();
            end
        end
        repeat (3) @(posedge clk);
    endtask
    function automatic void exp_sym(input logic [1:0] v);
        exp_q.push_back('{kind: K_SYM, val: v});
    endfunction
    function automatic void exp_byte(input logic [7:0] b,
        input logic pe, input logic od, input logic fl);
        for (int i = 0; i < 8; i++)
            exp_q.push_back('{kind: K_DATA, val: {1'b0, b[i]}});
        if (pe)
            exp_q.push_back('{kind: K_PAR, val: {1'b0, ^b ^ od ^ fl}});
    endfunction
    task automatic cmp_elems;
        check(peer.seen_q.size(), exp_q.size());
        foreach (exp_q[i])
            if (i < peer.seen_q.size())
                check(32'(peer.seen_q[i]), 32'(exp_q[i]));
        exp_q.delete();
        peer.seen_q.delete();
    endtask
    task automatic t_regs;
        logic [7:0] a[4] = '{`OFS_PULSE, `OFS_GUARD, `OFS_FRAME, 8'h30};
        logic [31:0] m[4] = '{`MASK_PULSE, `MASK_GUARD, `MASK_FRAME, 32'h0};
        foreach (a[i])
        begin
            rchk(a[i], `RST_REG);
            wr(a[i], 32'hffff_ffff);
            rchk(a[i], m[i]);
            wr(a[i], 32'h0);
        end
        wr(`OFS_CTRL, 32'hffff_fffe);
        rchk(`OFS_CTRL, `MASK_CTRL);
        wr(`OFS_CTRL, 32'h0);
    endtask
    task automatic t_detect;
        @(posedge clk);
        det <= '{valid: 1'b1, wait_val: 20'h00abc, reload: 8'h5a};
        bus <= '{addr: `OFS_GUARD, wdata: 32'h0123_4567, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        det.valid <= 1'b0;
        bus.wr <= 1'b0;
        rchk(`OFS_GUARD, 32'h000a_bc5a);
    endtask
    task automatic t_guard;
        // wait count, reload, first load, card role, expected ticks
        int c[4][5] = '{'{0, 127, 0, 0, 0}, '{3, 2, 0, 0, 9},
            '{2, 127, 0, 0, 256}, '{2, 5, 9, 1, 16}};
        wr(`OFS_FRAME, 32'h40);
        foreach (c[i])
        begin
            wr(`OFS_PULSE, 32'(c[i][2]));
            wr(`OFS_GUARD, {4'h0, 20'(c[i][0]), 8'(c[i][1])});
            go(9'h0, {1'b0, c[i][3] != 0});
            wait_idle();
            check(32'(first_ticks >= c[i][4] && first_ticks <= c[i][4] + 2),
                1);
            exp_sym(2'h0);
            cmp_elems();
            rchk(`OFS_ISTAT, 32'h1);
            wr(`OFS_ISTAT, 32'h3);
        end
    endtask
    task automatic t_frames;
        logic [7:0] b0, b1;
        logic [1:0] st, sp;
        logic pe, od, fl, py;
        wr(`OFS_GUARD, 32'h0);
        for (int k = 0; k < 5; k++)
        begin
            st = 2'(k + 1);
            sp = 2'(k);
            py = k != 4;
            pe = k != 0;
            od = 1'(k >> 1);
            fl = 1'(k);
            b0 = 8'(8'h35 + 29 * k);
            b1 = 8'hc6 ^ 8'(k);
            wr(`OFS_FRAME, {18'h0, fl, od, pe, py, sp, st, 6'h0});
            peer.src_q.push_back(b0);
            peer.src_q.push_back(b1);
            peer.stall = k == 1;
            go(9'h2, 2'b00);
            if (k == 1)
            begin
                repeat (100) @(posedge clk);
                check(peer.seen_q.size(), st != 0);
                peer.stall = 1'b0;
            end
            wait_idle();
            if (st != 0)
                exp_sym(st - 2'h1);
            if (py)
            begin
                exp_byte(b0, pe, od, 1'b0);
                exp_byte(b1, pe, od, fl);
            end
            if (sp != 0)
                exp_sym(sp);
            cmp_elems();
            peer.src_q.delete();
            rchk(`OFS_ISTAT, 32'h1);
            if (k == 0)
            begin
                check(irq, 1'b0);
                wr(`OFS_IMASK, 32'h1);
                repeat (2) @(posedge clk);
                check(irq, 1'b1);
            end
            wr(`OFS_ISTAT, 32'h1);
            repeat (2) @(posedge clk);
            check(irq, 1'b0);
        end
    endtask
    task automatic t_empty;
        wr(`OFS_FRAME, 32'h440);
        wr(`OFS_IMASK, 32'h2);
        go(9'h0, 2'b00);
        repeat (4) @(posedge clk);
        rchk(`OFS_ISTAT, 32'h2);
        check(irq, 1'b1);
        check(peer.seen_q.size(), 0);
        wr(`OFS_ISTAT, 32'h2);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        wr(`OFS_IMASK, 32'h0);
    endtask
    task automatic t_miller;
        wr(`OFS_PULSE, 32'h0000_0100);
        wr(`OFS_FRAME, 32'h400);
        peer.src_q.push_back(8'h81);
        go(9'h1, 2'b10);
        repeat (6) @(posedge clk);
        rchk(`OFS_CTRL, 32'h0001_000c);
        // a second start while busy must be ignored
        go(9'h1, 2'b10);
        wait_idle();
        check(32'(last_run >= 2 && last_run <= 3), 1);
        exp_byte(8'h81, 1'b0, 1'b0, 1'b0);
        cmp_elems();
        rchk(`OFS_ISTAT, 32'h1);
        wr(`OFS_ISTAT, 32'h1);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_detect();
        t_guard();
        t_frames();
        t_empty();
        t_miller();
        summarize();
    end
endmodule
